// ==== logic/bma_pkg.sv ====
// bma_pkg: address map, shared types and field kinds of the bus matrix
// assumes one system clock; every user of it imports the whole package
`default_nettype none
package bma_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [31:0] SRAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] SRAM_ALIAS  = 32'h2200_0000;
  localparam logic [31:0] PERI_BASE   = 32'h4000_0000;
  localparam logic [31:0] PERI_ALIAS  = 32'h4200_0000;
  localparam logic [31:0] ALIAS_OFFS  = 32'h0200_0000;
  localparam logic [31:0] ALIAS_BYTE  = 32'h0000_0020;
  localparam logic [31:0] ALIAS_BIT   = 32'h0000_0004;
  localparam logic [31:0] WORD_MASK   = 32'hffff_fffc;
  localparam logic [31:0] SRAM_BYTES  = 32'h0002_0000;
  localparam int          SRAM_WORDS  = 32768;
  localparam int          SRAM_AW     = 15;
  localparam logic [31:0] FLASH_BASE  = 32'h0800_0000;
  localparam logic [31:0] FLASH_SIZE  = 32'h0008_0000;
  localparam logic [31:0] APB1_BASE   = 32'h4000_0000;
  localparam logic [31:0] APB2_BASE   = 32'h4001_0000;
  localparam logic [31:0] APB_END     = 32'h4003_0000;
  localparam logic [31:0] IFETCH_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------
  // masters, slaves, sizes
  // ----------------------------------------------------------------
  localparam int         NMST     = 3;
  localparam logic [1:0] MST_CORE = 2'h0;
  localparam logic [1:0] MST_DBUS = 2'h1;
  localparam logic [1:0] MST_DMA  = 2'h2;
  localparam logic [1:0] MST_LAST = 2'h2;
  localparam logic [2:0] SL_SRAM  = 3'h0;
  localparam logic [2:0] SL_FLASH = 3'h1;
  localparam logic [2:0] SL_APB1  = 3'h2;
  localparam logic [2:0] SL_APB2  = 3'h3;
  localparam logic [2:0] SL_NONE  = 3'h4;
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [3:0] STRB_B   = 4'h1;
  localparam logic [3:0] STRB_H   = 4'h3;
  localparam logic [3:0] STRB_W   = 4'hf;
  localparam int         NAPB     = 2;
  localparam int         DIV_W    = 4;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ISSUE  = 5'h02,
    ST_WAIT   = 5'h04,
    ST_MODIFY = 5'h08,
    ST_RESP   = 5'h10
  } bma_state_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bma_req_type;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } bma_rsp_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } bma_ireq_type;

  typedef struct packed {
    logic [NAPB-1:0] psel;
    logic            penable;
    logic            pwrite;
    logic [31:0]     paddr;
    logic [31:0]     pwdata;
    logic [3:0]      pstrb;
  } bma_apb_type;

  // ----------------------------------------------------------------
  // register field kinds
  // ----------------------------------------------------------------
  localparam int         FLD_W     = 8;
  localparam int         FLD_N     = 11;
  localparam logic [7:0] FLD_FIXED = 8'h5a;
  localparam logic [7:0] FLD_RST   = 8'h00;

  typedef enum logic [3:0] {
    FK_FIXED_READONLY      = 4'h0,
    FK_HW_READONLY         = 4'h1,
    FK_READ_THEN_CLEAR     = 4'h2,
    FK_WRITE_THEN_CLEAR    = 4'h3,
    FK_WRITE_ONLY          = 4'h4,
    FK_PROTECTED_WRITEONLY = 4'h5,
    FK_PROTECTED_READWRITE = 4'h6,
    FK_WRITE_ONE_ACTS      = 4'h7,
    FK_WRITE_ZERO_ACTS     = 4'h8,
    FK_WRITE_ONE_TOGGLES   = 4'h9,
    FK_READ_WRITE          = 4'ha
  } bma_fld_kind_type;

  localparam bma_fld_kind_type FLD_KINDS [FLD_N] = '{
    FK_FIXED_READONLY, FK_HW_READONLY, FK_READ_THEN_CLEAR,
    FK_WRITE_THEN_CLEAR, FK_WRITE_ONLY, FK_PROTECTED_WRITEONLY,
    FK_PROTECTED_READWRITE, FK_WRITE_ONE_ACTS, FK_WRITE_ZERO_ACTS,
    FK_WRITE_ONE_TOGGLES, FK_READ_WRITE};

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic             hw_we;
    logic [FLD_W-1:0] wdata;
    logic [FLD_W-1:0] hw_val;
  } bma_fld_in_type;
endpackage : bma_pkg
`default_nettype wire

// ==== logic/bma_field.sv ====
// bma_field: one register field with a selectable access kind
// assumes strobes are one-cycle pulses synchronous to clock
`default_nettype none
module bma_field
  import bma_pkg::*;
#(
  parameter bma_fld_kind_type KIND = FK_READ_WRITE
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // access
  input  wire logic             safe_mode,
  input  wire bma_fld_in_type   acc,
  // field state
  output logic      [FLD_W-1:0] value,
  output logic      [FLD_W-1:0] rdata
);
  logic [FLD_W-1:0] q;
  logic [FLD_W-1:0] hw_bits;

  assign hw_bits = acc.hw_we ? acc.hw_val : '0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= (KIND == FK_FIXED_READONLY) ? FLD_FIXED : FLD_RST;
    end else begin
      case (KIND)
        FK_FIXED_READONLY: q <= FLD_FIXED;
        FK_HW_READONLY: if (acc.hw_we) q <= acc.hw_val;
        // a hardware set in the clearing cycle survives
        FK_READ_THEN_CLEAR: q <= (acc.rd ? '0 : q) | hw_bits;
        FK_WRITE_THEN_CLEAR: q <= acc.wr ? acc.wdata : '0;
        FK_WRITE_ONLY: if (acc.wr) q <= acc.wdata;
        FK_PROTECTED_WRITEONLY,
        FK_PROTECTED_READWRITE: if (acc.wr && safe_mode) q <= acc.wdata;
        // the action clears flagged bits; hardware sets win
        FK_WRITE_ONE_ACTS:
          q <= (q & ~(acc.wr ? acc.wdata : '0)) | hw_bits;
        FK_WRITE_ZERO_ACTS:
          q <= (q & (acc.wr ? acc.wdata : '1)) | hw_bits;
        FK_WRITE_ONE_TOGGLES: if (acc.wr) q <= q ^ acc.wdata;
        default: if (acc.wr) q <= acc.wdata;
      endcase
    end
  end

  assign value = q;

  // write-only kinds read back as zero
  always_comb begin
    case (KIND)
      FK_WRITE_THEN_CLEAR,
      FK_WRITE_ONLY,
      FK_PROTECTED_WRITEONLY: rdata = '0;
      default: rdata = q;
    endcase
  end
endmodule : bma_field
`default_nettype wire

// ==== logic/bma_matrix.sv ====
// bma_matrix: bus matrix with bit alias decoder, APB bridge, SRAM,
// instruction path with prefetch and a bank of typed register fields
// assumes masters hold valid until done; one system clock
// What this block does
// - alias = base + 0x2000000 + byte*32 + bit*4
// - alias read gives zero or non-zero
// - alias write sets or clears one bit only
// - alias covers SRAM and peripheral areas
// - alias decoding is a build option
// - data lanes are little-endian
// - SRAM takes byte, half, word accesses
// - one linear 32-bit address space
// - matrix arbitrates core, data, DMA masters
// - DMA reaches flash, SRAM and peripherals
// - bridge feeds two APB buses, own dividers
// - instruction fetches use own prefetching bus
// - separate data bus reaches flash data
// - read-then-clear field clears after read
// - write-then-clear field returns to zero
// - write-one-acts: one acts, zero ignored
// - write-zero-acts: zero acts, one ignored
// - toggle field inverts on written one
// - write-only field reads as zero
// - protected fields written only in safe mode
// - fixed field returns constant, ignores writes
// - hardware field ignores software writes
`default_nettype none
module bma_matrix
  import bma_pkg::*;
#(
  parameter bit ALIAS_EN = 1'b1
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  // masters: core system bus, core data bus, dma
  input  wire bma_req_type [NMST-1:0]     m_req,
  output bma_rsp_type      [NMST-1:0]     m_rsp,
  // instruction bus
  input  wire bma_ireq_type               ibus_req,
  output bma_rsp_type                     ibus_rsp,
  output bma_ireq_type                    flash_i_req,
  input  wire bma_rsp_type                flash_i_rsp,
  // flash data interface
  output bma_req_type                     flash_d_req,
  input  wire bma_rsp_type                flash_d_rsp,
  // apb buses
  input  wire logic [NAPB-1:0][DIV_W-1:0] apb_div,
  output logic      [NAPB-1:0]            apb_tick,
  output bma_apb_type                     apb,
  input  wire logic [NAPB-1:0]            pready,
  input  wire logic [NAPB-1:0][31:0]      prdata,
  // register fields
  input  wire logic                       safe_mode,
  input  wire bma_fld_in_type [FLD_N-1:0] fld_acc,
  output logic [FLD_N-1:0][FLD_W-1:0]     fld_value,
  output logic [FLD_N-1:0][FLD_W-1:0]     fld_rdata
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] decode(input logic [31:0] a);
    logic [2:0] s;
    s = SL_NONE;
    if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BYTES) s = SL_SRAM;
    else if (a >= FLASH_BASE && a < FLASH_BASE + FLASH_SIZE) s = SL_FLASH;
    else if (a >= APB1_BASE && a < APB2_BASE) s = SL_APB1;
    else if (a >= APB2_BASE && a < APB_END) s = SL_APB2;
    return s;
  endfunction : decode

  bma_state_type    state_q;
  logic [1:0]       gnt_q;
  logic [1:0]       last_q;
  bma_req_type      cur_q;
  logic             alias_q;
  logic [4:0]       bit_q;
  logic [2:0]       sel_q;
  logic             op_wr_q;
  logic [31:0]      op_addr_q;
  logic [31:0]      op_wdata_q;
  logic [3:0]       op_strb_q;
  logic [31:0]      rdata_q;
  logic [1:0]       pick;
  logic             any_req;
  logic [1:0]       idx;
  logic             in_alias;
  logic [31:0]      alias_base;
  logic [31:0]      alias_off;
  logic [31:0]      tgt_addr;
  logic [3:0]       strb;
  logic [31:0]      lanes;
  logic [31:0]      data_in;
  logic             done_op;
  logic [NAPB-1:0]  tick_q;
  logic             apb_b;
  logic [SRAM_AW-1:0] sram_idx;
  logic [31:0]      mem [0:SRAM_WORDS-1];

  // ----------------------------------------------------------------
  // round-robin arbitration
  // ----------------------------------------------------------------
  always_comb begin
    pick    = last_q;
    any_req = 1'b0;
    idx     = last_q;
    for (int k = 0; k < NMST; k++) begin
      idx = (idx == MST_LAST) ? MST_CORE : idx + 2'h1;
      if (!any_req && m_req[idx].valid) begin
        pick    = idx;
        any_req = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // alias translation and lane steering
  // ----------------------------------------------------------------
  always_comb begin
    alias_base = SRAM_BASE;
    in_alias   = 1'b0;
    if (ALIAS_EN) begin
      if (m_req[pick].addr >= SRAM_ALIAS &&
          m_req[pick].addr < SRAM_ALIAS + ALIAS_OFFS) begin
        alias_base = SRAM_BASE;
        in_alias   = 1'b1;
      end else if (m_req[pick].addr >= PERI_ALIAS &&
                   m_req[pick].addr < PERI_ALIAS + ALIAS_OFFS) begin
        alias_base = PERI_BASE;
        in_alias   = 1'b1;
      end
    end
    alias_off = m_req[pick].addr - alias_base - ALIAS_OFFS;
    tgt_addr  = in_alias ? alias_base + ((alias_off / ALIAS_BYTE) & WORD_MASK)
                         : m_req[pick].addr;
  end

  always_comb begin
    case (m_req[pick].size)
      SZ_BYTE: begin
        strb  = STRB_B << m_req[pick].addr[1:0];
        lanes = {4{m_req[pick].wdata[7:0]}};
      end
      SZ_HALF: begin
        strb  = STRB_H << {m_req[pick].addr[1], 1'b0};
        lanes = {2{m_req[pick].wdata[15:0]}};
      end
      default: begin
        strb  = STRB_W;
        lanes = m_req[pick].wdata;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // slave completion
  // ----------------------------------------------------------------
  assign apb_b = (sel_q == SL_APB2);
  always_comb begin
    done_op = 1'b0;
    data_in = rdata_q;
    case (sel_q)
      SL_SRAM: begin
        done_op = (state_q == ST_ISSUE);
        data_in = mem[sram_idx];
      end
      SL_FLASH: begin
        done_op = (state_q == ST_WAIT) && flash_d_rsp.done;
        data_in = flash_d_rsp.rdata;
      end
      default: begin
        done_op = (state_q == ST_WAIT) && tick_q[apb_b] && apb.penable &&
                  pready[apb_b];
        data_in = prdata[apb_b];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  // one path through the matrix keeps the read-modify-write atomic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      gnt_q      <= MST_CORE;
      last_q     <= MST_DMA;
      cur_q      <= '0;
      alias_q    <= 1'b0;
      bit_q      <= '0;
      sel_q      <= SL_NONE;
      op_wr_q    <= 1'b0;
      op_addr_q  <= '0;
      op_wdata_q <= '0;
      op_strb_q  <= '0;
      rdata_q    <= '0;
      m_rsp      <= '0;
    end else begin
      for (int k = 0; k < NMST; k++) m_rsp[k].done <= 1'b0;
      case (state_q)
        ST_IDLE: if (any_req) begin
          gnt_q      <= pick;
          last_q     <= pick;
          cur_q      <= m_req[pick];
          alias_q    <= in_alias;
          bit_q      <= alias_off[6:2];
          sel_q      <= decode(tgt_addr);
          op_wr_q    <= m_req[pick].write && !in_alias;
          op_addr_q  <= tgt_addr & WORD_MASK;
          op_wdata_q <= lanes;
          op_strb_q  <= in_alias ? STRB_W : strb;
          if (decode(tgt_addr) == SL_NONE) begin
            m_rsp[pick].done <= 1'b1;
            m_rsp[pick].err  <= 1'b1;
            state_q          <= ST_RESP;
          end else begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (sel_q == SL_SRAM) begin
            rdata_q <= data_in;
          end
          if (done_op) begin
            state_q <= ST_MODIFY;
          end else if (sel_q == SL_FLASH || tick_q[apb_b]) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: if (done_op) begin
          rdata_q <= data_in;
          state_q <= ST_MODIFY;
        end
        ST_MODIFY: begin
          if (alias_q && cur_q.write && !op_wr_q) begin
            op_wr_q                <= 1'b1;
            op_wdata_q             <= rdata_q;
            op_wdata_q[bit_q]      <= cur_q.wdata[0];
            state_q                <= ST_ISSUE;
          end else begin
            m_rsp[gnt_q].done  <= 1'b1;
            m_rsp[gnt_q].err   <= 1'b0;
            m_rsp[gnt_q].rdata <= alias_q ? {31'h0, rdata_q[bit_q]}
                                          : rdata_q;
            state_q            <= ST_RESP;
          end
        end
        ST_RESP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sram
  // ----------------------------------------------------------------
  assign sram_idx = op_addr_q[SRAM_AW+1:2];
  always_ff @(posedge clock) begin
    if (state_q == ST_ISSUE && sel_q == SL_SRAM && op_wr_q) begin
      for (int b = 0; b < 4; b++) begin
        if (op_strb_q[b]) mem[sram_idx][b*8 +: 8] <= op_wdata_q[b*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // flash data port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_d_req <= '0;
    end else if (state_q == ST_ISSUE && sel_q == SL_FLASH) begin
      flash_d_req.valid <= 1'b1;
      flash_d_req.write <= op_wr_q;
      flash_d_req.size  <= cur_q.size;
      flash_d_req.addr  <= op_addr_q;
      flash_d_req.wdata <= op_wdata_q;
    end else if (flash_d_rsp.done) begin
      flash_d_req.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb bridge, one divided clock enable per bus
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NAPB; g++) begin : g_div
    logic [DIV_W-1:0] cnt_q;
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q     <= '0;
        tick_q[g] <= 1'b0;
      end else begin
        tick_q[g] <= (cnt_q == apb_div[g]);
        cnt_q     <= (cnt_q == apb_div[g]) ? '0 : cnt_q + 1'b1;
      end
    end
  end
  assign apb_tick = tick_q;

  // apb signals only move on the selected bus's own tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      apb <= '0;
    end else if (sel_q == SL_APB1 || sel_q == SL_APB2) begin
      if (state_q == ST_ISSUE && tick_q[apb_b]) begin
        apb.psel[apb_b] <= 1'b1;
        apb.penable     <= 1'b0;
        apb.pwrite      <= op_wr_q;
        apb.paddr       <= op_addr_q;
        apb.pwdata      <= op_wdata_q;
        apb.pstrb       <= op_wr_q ? op_strb_q : '0;
      end else if (state_q == ST_WAIT && tick_q[apb_b]) begin
        if (!apb.penable) begin
          apb.penable <= 1'b1;
        end else if (pready[apb_b]) begin
          apb.psel    <= '0;
          apb.penable <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction bus with one-word prefetch
  // ----------------------------------------------------------------
  logic        pf_valid_q;
  logic        demand_q;
  logic [31:0] pf_addr_q;
  logic [31:0] pf_data_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pf_valid_q  <= 1'b0;
      demand_q    <= 1'b0;
      pf_addr_q   <= '0;
      pf_data_q   <= '0;
      flash_i_req <= '0;
      ibus_rsp    <= '0;
    end else begin
      ibus_rsp.done <= 1'b0;
      if (flash_i_req.valid) begin
        if (flash_i_rsp.done) begin
          if (demand_q) begin
            ibus_rsp.done     <= 1'b1;
            ibus_rsp.rdata    <= flash_i_rsp.rdata;
            ibus_rsp.err      <= 1'b0;
            demand_q          <= 1'b0;
            flash_i_req.addr  <= flash_i_req.addr + IFETCH_STEP;
            pf_valid_q        <= 1'b0;
          end else begin
            flash_i_req.valid <= 1'b0;
            pf_valid_q        <= 1'b1;
            pf_addr_q         <= flash_i_req.addr;
            pf_data_q         <= flash_i_rsp.rdata;
          end
        end
      end else if (ibus_req.valid && !ibus_rsp.done) begin
        if (pf_valid_q && pf_addr_q == ibus_req.addr) begin
          ibus_rsp.done     <= 1'b1;
          ibus_rsp.rdata    <= pf_data_q;
          ibus_rsp.err      <= 1'b0;
          pf_valid_q        <= 1'b0;
          flash_i_req.valid <= 1'b1;
          flash_i_req.addr  <= ibus_req.addr + IFETCH_STEP;
        end else begin
          demand_q          <= 1'b1;
          flash_i_req.valid <= 1'b1;
          flash_i_req.addr  <= ibus_req.addr;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  for (genvar f = 0; f < FLD_N; f++) begin : g_fld
    logic [FLD_W-1:0] rd_w;
    bma_field #(
      .KIND (FLD_KINDS[f])
    ) u_fld (
      .clock     (clock),
      .arst_n    (arst_n),
      .safe_mode (safe_mode),
      .acc       (fld_acc[f]),
      .value     (fld_value[f]),
      .rdata     (rd_w)
    );
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) fld_rdata[f] <= '0;
      else if (fld_acc[f].rd) fld_rdata[f] <= rd_w;
    end
  end
endmodule : bma_matrix
`default_nettype wire

// ==== test/bma_partner.sv ====
// bma_partner: flash and apb slaves facing the matrix
// assumes matrix holds valid until done
`default_nettype none
module bma_partner
  import bma_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // flash side
  input  wire bma_ireq_type      flash_i_req,
  output bma_rsp_type            flash_i_rsp,
  input  wire bma_req_type       flash_d_req,
  output bma_rsp_type            flash_d_rsp,
  // apb side
  input  wire bma_apb_type       apb,
  output wire logic [NAPB-1:0]   pready,
  output wire logic [NAPB-1:0][31:0] prdata
);
  timeunit 1ns / 100ps;
  // flash data reads back as inverted address so a wrong lane shows
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_i_rsp <= '0;
      flash_d_rsp <= '0;
    end else begin
      flash_i_rsp.done  <= flash_i_req.valid & ~flash_i_rsp.done;
      flash_i_rsp.rdata <= ~flash_i_req.addr;
      flash_d_rsp.done  <= flash_d_req.valid & ~flash_d_rsp.done;
      flash_d_rsp.rdata <= ~flash_d_req.addr;
    end
  end
  assign pready = 2'h3;
  assign prdata = {2{apb.paddr ^ 32'h0f0f_0f0f}};
endmodule : bma_partner
`default_nettype wire

// ==== test/bma_checker.sv ====
// bma_checker: port-level properties of the bus matrix
// assumes it is bound to bma_matrix, one clock domain
`default_nettype none
module bma_checker
  import bma_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       arst_n,
  input wire bma_req_type [NMST-1:0]     m_req,
  input wire bma_rsp_type [NMST-1:0]     m_rsp,
  input wire bma_apb_type                apb,
  input wire logic                       safe_mode,
  input wire bma_fld_in_type [FLD_N-1:0] fld_acc,
  input wire logic [FLD_N-1:0][FLD_W-1:0] fld_value
);
  timeunit 1ns / 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_alias_rd;
    m_req[0].valid && !m_req[0].write && m_req[0].addr[31:24] == 8'h22 ##0 m_rsp[0].done;
  endsequence
  sequence s_clr_rd;
    fld_acc[2].rd && !fld_acc[2].hw_we;
  endsequence
  a_done_pulse: assert property (m_rsp[0].done |=> !m_rsp[0].done)
    else $error("done held over one cycle");
  a_one_grant: assert property ($onehot0({m_rsp[0].done,m_rsp[1].done,m_rsp[2].done}))
    else $error("two masters answered at once");
  a_alias_bool: assert property (s_alias_rd |-> m_rsp[0].rdata <= 32'h1)
    else $error("alias read not zero or one");
  a_fixed_const: assert property (fld_value[0] == FLD_FIXED)
    else $error("fixed field changed");
  a_prot_ignore: assert property (fld_acc[5].wr && !safe_mode |=>
    $stable(fld_value[5]))
    else $error("protected field written");
  a_toggle_flip: assert property (fld_acc[9].wr && !fld_acc[9].hw_we |=>
    fld_value[9] == ($past(fld_value[9]) ^ $past(fld_acc[9].wdata)))
    else $error("toggle field wrong");
  a_hw_ignore: assert property (fld_acc[1].wr && !fld_acc[1].hw_we |=>
    $stable(fld_value[1]))
    else $error("hw field took a write");
  a_wz_clear: assert property (fld_acc[3].wr |-> ##[1:2] fld_value[3] == 8'h00)
    else $error("write-then-clear field stuck");
  a_rz_clear: assert property (s_clr_rd |=> fld_value[2] == 8'h00)
    else $error("read-clear field kept value");
  a_apb_sel: assert property (apb.penable |-> $onehot(apb.psel))
    else $error("access phase select wrong");
endmodule : bma_checker
`default_nettype wire

// ==== test/bma_matrix_tb_top.sv ====
// bma_matrix_tb_top: directed tests of the bus matrix
// assumes bma_partner stands in for flash and apb slaves
`default_nettype none
module bma_matrix_tb_top;
  import bma_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, arst_n, safe_mode;
  bma_req_type [NMST-1:0] m_req;
  bma_rsp_type [NMST-1:0] m_rsp;
  bma_rsp_type ibus_rsp, fi_rsp, fd_rsp, r0, r2;
  bma_ireq_type ibus_req, fi_req;
  bma_req_type fd_req;
  bma_apb_type apb;
  logic [NAPB-1:0][DIV_W-1:0] apb_div;
  logic [NAPB-1:0] apb_tick, pready;
  logic [NAPB-1:0][31:0] prdata;
  bma_fld_in_type [FLD_N-1:0] fld_acc;
  logic [FLD_N-1:0][FLD_W-1:0] fld_value, fld_rdata;
  int n_fail = 0;
  int checks_done = 0;
  bma_matrix bma_matrix_inst (.clock, .arst_n, .m_req, .m_rsp, .ibus_req, .ibus_rsp,
    .flash_i_req(fi_req), .flash_i_rsp(fi_rsp), .flash_d_req(fd_req), .flash_d_rsp(fd_rsp),
    .apb_div, .apb_tick, .apb, .pready, .prdata, .safe_mode, .fld_acc, .fld_value, .fld_rdata);
  bma_partner bma_partner_inst (.clock, .arst_n, .flash_i_req(fi_req), .flash_i_rsp(fi_rsp),
    .flash_d_req(fd_req), .flash_d_rsp(fd_rsp), .apb, .pready, .prdata);
  // ----
  // shared tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input int m, input logic w, input logic [1:0] sz,
                      input logic [31:0] a, input logic [31:0] d, output bma_rsp_type r);
    @(posedge clock);
    m_req[m] <= '{1'b1, w, sz, a, d};
    repeat (60) if (m_rsp[m].done !== 1'b1) @(negedge clock);
    chk("done", 32'h1, {31'h0, m_rsp[m].done});
    r = m_rsp[m];
    @(posedge clock);
    m_req[m].valid <= 1'b0;
  endtask : xfer
  task automatic rd(input int m, input logic [31:0] a, input logic [31:0] e, input string s);
    bma_rsp_type r;
    xfer(m, 1'b0, 2'h2, a, 32'h0, r);
    chk(s, e, r.rdata);
  endtask : rd
  task automatic fw(input int k, input logic [3:0] c, input logic [7:0] d, input logic [7:0] e);
    @(posedge clock);
    fld_acc[k] <= '{c[3], c[2], c[1], d, d};
    @(posedge clock);
    fld_acc[k] <= '0;
    if (c[0]) repeat (2) @(posedge clock);
    @(negedge clock);
    chk($sformatf("field %0d", k), {24'h0, e}, {24'h0, c[2] ? fld_rdata[k] : fld_value[k]});
  endtask : fw
  task automatic fetch(input logic [31:0] a);
    @(posedge clock);
    ibus_req <= '{1'b1, a};
    repeat (9) if (ibus_rsp.done !== 1'b1) @(negedge clock);
    chk("fetch", ~a, ibus_rsp.rdata);
    @(posedge clock);
    ibus_req.valid <= 1'b0;
  endtask : fetch
  // ----
  // scenarios
  // ----
  task automatic t_sram;
    bma_rsp_type r;
    xfer(0, 1'b1, 2'h2, 32'h2000_0100, 32'h0, r);
    xfer(0, 1'b1, SZ_BYTE, 32'h2000_0101, 32'h0000_00a5, r);
    xfer(0, 1'b1, SZ_HALF, 32'h2000_0102, 32'h0000_1234, r);
    rd(0, 32'h2000_0100, 32'h1234_a500, "sram lanes");
  endtask : t_sram
  task automatic t_alias;
    bma_rsp_type r;
    xfer(0, 1'b1, 2'h2, 32'h2200_200c, 32'h1, r);
    rd(0, 32'h2000_0100, 32'h1234_a508, "alias set");
    rd(0, 32'h2200_200c, 32'h1, "alias read");
    xfer(2, 1'b1, 2'h2, 32'h2200_200c, 32'h0, r);
    rd(2, 32'h2000_0100, 32'h1234_a500, "alias clear");
    rd(0, 32'h4220_0080, 32'h1, "peri alias");
  endtask : t_alias
  task automatic t_map;
    bma_rsp_type r;
    xfer(0, 1'b0, 2'h2, 32'h6000_0000, 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, r.err});
    rd(2, 32'h0800_0010, 32'hf7ff_ffef, "dma flash");
    rd(1, 32'h0800_0020, 32'hf7ff_ffdf, "data bus flash");
    rd(2, 32'h4000_0008, 32'h4f0f_0f07, "apb1");
    rd(2, 32'h4001_0004, 32'h4f0e_0f0b, "apb2");
  endtask : t_map
  task automatic t_arb;
    fork
      xfer(0, 1'b0, 2'h2, 32'h2000_0100, 32'h0, r0);
      xfer(2, 1'b0, 2'h2, 32'h2000_0100, 32'h0, r2);
    join
    chk("core arb", 32'h1234_a500, r0.rdata);
    chk("dma arb", 32'h1234_a500, r2.rdata);
  endtask : t_arb
  task automatic t_fld;
    fw(0, 4'h8, 8'h33, FLD_FIXED);
    fw(1, 4'h8, 8'h33, 8'h00);
    fw(5, 4'h8, 8'h33, 8'h00);
    fw(6, 4'h8, 8'h33, 8'h00);
    @(posedge clock);
    safe_mode <= 1'b1;
    fw(6, 4'h8, 8'h33, 8'h33);
    fw(9, 4'h8, 8'hff, 8'hff);
    fw(9, 4'h8, 8'h0f, 8'hf0);
    fw(7, 4'h2, 8'hff, 8'hff);
    fw(7, 4'h8, 8'h0f, 8'hf0);
    fw(8, 4'h2, 8'hff, 8'hff);
    fw(8, 4'h8, 8'h0f, 8'h0f);
    fw(2, 4'h2, 8'h55, 8'h55);
    fw(2, 4'h4, 8'h00, 8'h55);
    fw(2, 4'h0, 8'h00, 8'h00);
    fw(4, 4'h8, 8'h33, 8'h33);
    fw(4, 4'h4, 8'h00, 8'h00);
    fw(3, 4'h9, 8'h33, 8'h00);
  endtask : t_fld
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #100us;
    n_fail++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    safe_mode = 1'b0;
    m_req = '0;
    ibus_req = '0;
    apb_div = {4'h2, 4'h1};
    fld_acc = '0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    t_sram();
    t_alias();
    t_map();
    t_arb();
    fetch(32'h0800_0040);
    fetch(32'h0800_0044);
    t_fld();
    conclude();
  end
endmodule : bma_matrix_tb_top
bind bma_matrix bma_checker bma_checker_inst (.clock, .arst_n, .m_req, .m_rsp, .apb,
  .safe_mode, .fld_acc, .fld_value);
`default_nettype wire
